// ==== mrr_exec.v ====
// execution unit for accumulator moves, stack returns and left rotate
`timescale 1ns/1ps
`include "mrr_consts.vh"

module mrr_exec
#(
  parameter DATA_W = `MRR_DATA_W,
  parameter FADDR_W = `MRR_FADDR_W,
  parameter PC_W = `MRR_PC_W
)
(
  input wire CLK_I,
  input wire RSTN_I,
  input wire INSTR_VALID_I,
  input wire [`MRR_INSTR_W-1:0] INSTR_I,
  input wire [DATA_W-1:0] FILE_RDATA_I,
  input wire [PC_W-1:0] STACK_TOP_I,
  input wire GIE_CLR_I,
  output reg [DATA_W-1:0] ACCUM_O,
  output reg CARRY_O,
  output reg GIE_O,
  output reg FILE_WE_O,
  output reg [FADDR_W-1:0] FILE_ADDR_O,
  output reg [DATA_W-1:0] FILE_WDATA_O,
  output reg STACK_POP_O,
  output reg PC_LOAD_O,
  output reg [PC_W-1:0] PC_VALUE_O,
  output reg PC_INC_O,
  output reg BUSY_O,
  output reg ILLEGAL_O
);

  localparam ST_EXEC = 1'b0;
  localparam ST_FLUSH = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // decode

  wire is_acc2file;
  wire is_lit2acc;
  wire is_idle;
  wire is_irq_ret;
  wire is_lit_ret;
  wire is_sub_ret;
  wire is_rotl;
  wire is_known;

  mrr_decode u_decode
  (
    .instr_i(INSTR_I),
    .acc2file_o(is_acc2file),
    .lit2acc_o(is_lit2acc),
    .idle_o(is_idle),
    .irq_ret_o(is_irq_ret),
    .lit_ret_o(is_lit_ret),
    .sub_ret_o(is_sub_ret),
    .rotl_o(is_rotl),
    .known_o(is_known)
  );

  wire [DATA_W-1:0] literal = INSTR_I[DATA_W-1:0];
  wire [FADDR_W-1:0] faddr = INSTR_I[FADDR_W-1:0];
  wire dest_file = INSTR_I[`MRR_DEST_BIT];

  ////////////////////////////////////////////////////////////////////////
  // state

  reg state_ff;
  reg nxt_state;
  reg [DATA_W-1:0] nxt_accum;
  reg nxt_carry;
  reg nxt_gie;
  reg nxt_file_we;
  reg [FADDR_W-1:0] nxt_file_addr;
  reg [DATA_W-1:0] nxt_file_wdata;
  reg nxt_stack_pop;
  reg nxt_pc_load;
  reg [PC_W-1:0] nxt_pc_value;
  reg nxt_pc_inc;
  reg nxt_busy;
  reg nxt_illegal;
  reg [DATA_W-1:0] rot_result;
  reg rot_carry;

  // instruction is taken only when valid and no return is being flushed
  wire take = INSTR_VALID_I & (state_ff == ST_EXEC);

  always @*
  begin
    // rotate through carry, result and new carry
    {rot_carry, rot_result} = {FILE_RDATA_I, CARRY_O};

    nxt_state = state_ff;
    nxt_accum = ACCUM_O;
    nxt_carry = CARRY_O;
    nxt_gie = GIE_O;
    nxt_file_we = 1'b0;
    nxt_file_addr = FILE_ADDR_O;
    nxt_file_wdata = FILE_WDATA_O;
    nxt_stack_pop = 1'b0;
    nxt_pc_load = 1'b0;
    nxt_pc_value = PC_VALUE_O;
    nxt_pc_inc = 1'b0;
    nxt_busy = 1'b0;
    nxt_illegal = 1'b0;

    case (state_ff)
      ST_EXEC:
      begin
        if (take)
        begin
          if (is_acc2file)
          begin
            nxt_file_we = 1'b1;
            nxt_file_addr = faddr;
            nxt_file_wdata = ACCUM_O;
            nxt_pc_inc = 1'b1;
          end
          else if (is_lit2acc)
          begin
            nxt_accum = literal;
            nxt_pc_inc = 1'b1;
          end
          else if (is_rotl)
          begin
            nxt_carry = rot_carry;
            nxt_pc_inc = 1'b1;
            if (dest_file)
            begin
              nxt_file_we = 1'b1;
              nxt_file_addr = faddr;
              nxt_file_wdata = rot_result;
            end
            else
            begin
              nxt_accum = rot_result;
            end
          end
          else if (is_irq_ret | is_lit_ret | is_sub_ret)
          begin
            // the popped entry is the return address; the second cycle
            // discards the already-fetched word after it
            nxt_stack_pop = 1'b1;
            nxt_pc_load = 1'b1;
            nxt_pc_value = STACK_TOP_I;
            nxt_busy = 1'b1;
            nxt_state = ST_FLUSH;
            if (is_lit_ret)
            begin
              nxt_accum = literal;
            end
            if (is_irq_ret)
            begin
              nxt_gie = 1'b1;
            end
          end
          else if (is_idle)
          begin
            nxt_pc_inc = 1'b1;
          end
          else
          begin
            // words outside this group belong to other units; flagged
            // only so an integrator can see a word nobody executed
            nxt_illegal = ~is_known;
          end
        end
      end
      ST_FLUSH:
      begin
        nxt_state = ST_EXEC;
      end
      default:
      begin
        nxt_state = ST_EXEC;
      end
    endcase

    // interrupt entry clears the enable, but a return in the same
    // cycle sets it again: the set wins
    if (GIE_CLR_I & ~(take & is_irq_ret))
    begin
      nxt_gie = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      state_ff <= ST_EXEC;
      ACCUM_O <= `MRR_ACCUM_RST;
      CARRY_O <= `MRR_CARRY_RST;
      GIE_O <= `MRR_GIE_RST;
      FILE_WE_O <= 1'b0;
      FILE_ADDR_O <= {FADDR_W{1'b0}};
      FILE_WDATA_O <= {DATA_W{1'b0}};
      STACK_POP_O <= 1'b0;
      PC_LOAD_O <= 1'b0;
      PC_VALUE_O <= {PC_W{1'b0}};
      PC_INC_O <= 1'b0;
      BUSY_O <= 1'b0;
      ILLEGAL_O <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      ACCUM_O <= nxt_accum;
      CARRY_O <= nxt_carry;
      GIE_O <= nxt_gie;
      FILE_WE_O <= nxt_file_we;
      FILE_ADDR_O <= nxt_file_addr;
      FILE_WDATA_O <= nxt_file_wdata;
      STACK_POP_O <= nxt_stack_pop;
      PC_LOAD_O <= nxt_pc_load;
      PC_VALUE_O <= nxt_pc_value;
      PC_INC_O <= nxt_pc_inc;
      BUSY_O <= nxt_busy;
      ILLEGAL_O <= nxt_illegal;
    end
  end

endmodule // mrr_exec

// ==== mrr_consts.vh ====
// constants for the move, return and rotate execution block
`ifndef MRR_CONSTS_VH
`define MRR_CONSTS_VH

`define MRR_INSTR_W 14
`define MRR_DATA_W 8
`define MRR_FADDR_W 7
`define MRR_PC_W 13

// decode masks and match values, don't-care bits are zero in the mask
`define MRR_MSK_ACC2FILE 14'h3F80
`define MRR_VAL_ACC2FILE 14'h0080
`define MRR_MSK_LIT2ACC 14'h3C00
`define MRR_VAL_LIT2ACC 14'h3000
`define MRR_MSK_IDLE 14'h3F9F
`define MRR_VAL_IDLE 14'h0000
`define MRR_MSK_IRQRET 14'h3FFF
`define MRR_VAL_IRQRET 14'h0009
`define MRR_MSK_LITRET 14'h3C00
`define MRR_VAL_LITRET 14'h3400
`define MRR_MSK_SUBRET 14'h3FFF
`define MRR_VAL_SUBRET 14'h0008
`define MRR_MSK_ROTL 14'h3F00
`define MRR_VAL_ROTL 14'h0D00

// field positions
`define MRR_DEST_BIT 7
`define MRR_GIE_BIT 7

// reset values
`define MRR_ACCUM_RST 8'h00
`define MRR_CARRY_RST 1'h0
`define MRR_GIE_RST 1'h0

// cycle counts per instruction
`define MRR_CYC_SHORT 2'h1
`define MRR_CYC_RETURN 2'h2

`endif

// ==== mrr_decode.v ====
// instruction word decoder for the move, return and rotate group
`timescale 1ns/1ps
`include "mrr_consts.vh"

module mrr_decode
(
  input wire [`MRR_INSTR_W-1:0] instr_i,
  output wire acc2file_o,
  output wire lit2acc_o,
  output wire idle_o,
  output wire irq_ret_o,
  output wire lit_ret_o,
  output wire sub_ret_o,
  output wire rotl_o,
  output wire known_o
);

  ////////////////////////////////////////////////////////////////////////
  // masked compares; bits outside each mask are ignored so an assembler
  // that leaves don't-care bits nonzero still decodes the same way
  assign acc2file_o =
    (instr_i & `MRR_MSK_ACC2FILE) == `MRR_VAL_ACC2FILE;
  assign lit2acc_o = (instr_i & `MRR_MSK_LIT2ACC) == `MRR_VAL_LIT2ACC;
  assign idle_o = (instr_i & `MRR_MSK_IDLE) == `MRR_VAL_IDLE;
  assign irq_ret_o = (instr_i & `MRR_MSK_IRQRET) == `MRR_VAL_IRQRET;
  assign lit_ret_o = (instr_i & `MRR_MSK_LITRET) == `MRR_VAL_LITRET;
  assign sub_ret_o = (instr_i & `MRR_MSK_SUBRET) == `MRR_VAL_SUBRET;
  assign rotl_o = (instr_i & `MRR_MSK_ROTL) == `MRR_VAL_ROTL;

  assign known_o = acc2file_o | lit2acc_o | idle_o | irq_ret_o |
    lit_ret_o | sub_ret_o | rotl_o;

endmodule // mrr_decode

// ==== mrr_exec_assertions.sv ====
// assertion checker for the move, return and rotate execution block
`timescale 1ns/1ps
`include "mrr_consts.vh"
module mrr_exec_chk
(
  input wire CLK_I,
  input wire RSTN_I,
  input wire INSTR_VALID_I,
  input wire [13:0] INSTR_I,
  input wire [7:0] FILE_RDATA_I,
  input wire [12:0] STACK_TOP_I,
  input wire GIE_CLR_I,
  input wire [7:0] ACCUM_O,
  input wire CARRY_O,
  input wire GIE_O,
  input wire FILE_WE_O,
  input wire [6:0] FILE_ADDR_O,
  input wire [7:0] FILE_WDATA_O,
  input wire STACK_POP_O,
  input wire PC_LOAD_O,
  input wire [12:0] PC_VALUE_O,
  input wire PC_INC_O,
  input wire BUSY_O
);
  // operands captured at the taking edge, compared one edge later
  reg [7:0] rot_ff;
  reg dst_ff;
  always @(posedge CLK_I)
  begin
    rot_ff <= {FILE_RDATA_I[6:0], CARRY_O};
    dst_ff <= INSTR_I[`MRR_DEST_BIT];
  end
  function automatic logic hit(input [13:0] w, input [13:0] m, v);
    hit = (w & m) == v;
  endfunction
  wire tk = INSTR_VALID_I && !BUSY_O;
  wire a2f = tk && hit(INSTR_I, `MRR_MSK_ACC2FILE, `MRR_VAL_ACC2FILE);
  wire l2a = tk && hit(INSTR_I, `MRR_MSK_LIT2ACC, `MRR_VAL_LIT2ACC);
  wire idle_instruction = tk && hit(INSTR_I, `MRR_MSK_IDLE, `MRR_VAL_IDLE);
  wire iret = tk && hit(INSTR_I, `MRR_MSK_IRQRET, `MRR_VAL_IRQRET);
  wire lret = tk && hit(INSTR_I, `MRR_MSK_LITRET, `MRR_VAL_LITRET);
  wire sret = tk && hit(INSTR_I, `MRR_MSK_SUBRET, `MRR_VAL_SUBRET);
  wire rotl = tk && hit(INSTR_I, `MRR_MSK_ROTL, `MRR_VAL_ROTL);
  //////////////////////////////////////////
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  sequence pop_s;
    STACK_POP_O && PC_LOAD_O && BUSY_O && PC_VALUE_O == $past(STACK_TOP_I)
    ##1 !STACK_POP_O && !PC_LOAD_O && !BUSY_O;
  endsequence
  a2f_write_a: assert property (a2f |=> FILE_WE_O && PC_INC_O &&
    FILE_ADDR_O == $past(INSTR_I[6:0]) && FILE_WDATA_O == $past(ACCUM_O)
    && $stable(CARRY_O)) else $error("accumulator store wrong");
  lit_load_a: assert property (l2a |=> ACCUM_O == $past(INSTR_I[7:0])
    && $stable(CARRY_O) && PC_INC_O) else $error("literal load wrong");
  irq_return_a: assert property (iret |=> GIE_O ##0 pop_s)
    else $error("interrupt return wrong");
  lit_return_a: assert property (lret |=>
    ACCUM_O == $past(INSTR_I[7:0]) ##0 pop_s) else $error("literal return");
  sub_return_a: assert property (sret |=> $stable(ACCUM_O)
    && $stable(CARRY_O) ##0 pop_s) else $error("subroutine return wrong");
  rotl_carry_a: assert property (rotl |=> PC_INC_O
    && CARRY_O == $past(FILE_RDATA_I[7])) else $error("rotate carry wrong");
  rotl_dest_a: assert property (rotl |=> (dst_ff ? FILE_WE_O &&
    FILE_WDATA_O == rot_ff : !FILE_WE_O && ACCUM_O == rot_ff))
    else $error("rotate destination wrong");
  idle_step_a: assert property (idle_instruction |=> PC_INC_O && !FILE_WE_O
    && !STACK_POP_O && $stable(ACCUM_O) && $stable(CARRY_O))
    else $error("idle changed state");
  flush_drop_a: assert property (BUSY_O && INSTR_VALID_I |=>
    !PC_INC_O && !FILE_WE_O && $stable(ACCUM_O)) else $error("flush taken");
  gie_clear_a: assert property (GIE_CLR_I && !iret |=> !GIE_O)
    else $error("interrupt enable not cleared");
endmodule // mrr_exec_chk
bind mrr_exec mrr_exec_chk u_chk (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
  .INSTR_VALID_I(INSTR_VALID_I), .INSTR_I(INSTR_I),
  .FILE_RDATA_I(FILE_RDATA_I), .STACK_TOP_I(STACK_TOP_I), .ACCUM_O(ACCUM_O),
  .CARRY_O(CARRY_O), .GIE_O(GIE_O), .FILE_WE_O(FILE_WE_O),
  .FILE_ADDR_O(FILE_ADDR_O), .FILE_WDATA_O(FILE_WDATA_O),
  .STACK_POP_O(STACK_POP_O), .PC_LOAD_O(PC_LOAD_O),
  .PC_VALUE_O(PC_VALUE_O), .PC_INC_O(PC_INC_O), .BUSY_O(BUSY_O),
  .GIE_CLR_I(GIE_CLR_I));

// ==== move_return_rotate_exec_tb.sv ====
// self-checking bench for the move, return and rotate execution block
`timescale 1ns/1ps
module move_return_rotate_exec_tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg vld = 1'b0;
  reg gclr = 1'b0;
  reg [13:0] ins = 14'h0000;
  reg [7:0] rd = 8'h00;
  reg [12:0] top = 13'h0000;
  wire [7:0] acc, wdat;
  wire [6:0] adr;
  wire [12:0] pcv;
  wire cy, global_irq_enable, we, pop, pcl, inc, busy, ill;
  integer n_mismatch = 0;
  integer total_checks = 0;
  integer m_acc = 0, m_cy = 0, m_gie = 0, i;
  always #25 clk = ~clk;
  mrr_exec dut (.CLK_I(clk), .RSTN_I(rst_n), .INSTR_VALID_I(vld),
    .INSTR_I(ins), .FILE_RDATA_I(rd), .STACK_TOP_I(top), .GIE_CLR_I(gclr),
    .ACCUM_O(acc), .CARRY_O(cy), .GIE_O(global_irq_enable), .FILE_WE_O(we),
    .FILE_ADDR_O(adr), .FILE_WDATA_O(wdat), .STACK_POP_O(pop),
    .PC_LOAD_O(pcl), .PC_VALUE_O(pcv), .PC_INC_O(inc), .BUSY_O(busy),
    .ILLEGAL_O(ill));
  //////////////////////////////////////////
  task chk(input string nm, input logic [31:0] s, e);
    total_checks = total_checks + 1;
    if (s !== e)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // op 0..8: store, load, idle, irq ret, lit ret, ret, rotate, unknown,
  // gap (valid low); each call starts and ends on a falling edge so a
  // word is never offered for a second, unmodelled take
  task run(input integer op);
    reg [13:0] w;
    reg [6:0] f;
    reg [7:0] k, r, ed;
    reg [5:0] ep;
    reg d, ewe, epop;
    f = $urandom;
    k = $urandom;
    d = $urandom;
    rd = $urandom;
    top = $urandom;
    gclr = ($urandom % 4) == 0;
    case (op)
      0: w = {7'h01, f};
      1: w = {6'h30, k}; // don't-care bits left zero
      2: w = {7'h00, k[1:0], 5'h00};
      3: w = 14'h0009;
      4: w = {6'h34, k};
      5: w = 14'h0008;
      6: w = {6'h0D, d, f};
      8: w = $urandom;
      default: w = 14'h3FFF;
    endcase
    r = {rd[6:0], m_cy[0]};
    epop = op == 3 || op == 4 || op == 5;
    ewe = op == 0 || (op == 6 && d);
    ed = (op == 0) ? m_acc[7:0] : r;
    ep = {ewe, epop, epop, epop, op < 3 || op == 6, op == 7};
    ins = w;
    vld = op != 8;
    @(negedge clk);
    if (op == 1 || op == 4 || (op == 6 && !d))
      m_acc = (op == 6) ? r : k;
    if (op == 6)
      m_cy = rd[7];
    m_gie = (op == 3) ? 1 : gclr ? 0 : m_gie;
    chk("accum", acc, m_acc);
    chk("carry", cy, m_cy);
    chk("gie", global_irq_enable, m_gie);
    chk("pulses", {we, pop, pcl, busy, inc, ill}, ep);
    if (ewe)
      chk("write", {adr, wdat}, {f, ed});
    if (epop)
    begin
      chk("pc", pcv, top);
      // the word offered in the flush cycle must be dropped
      ins = $urandom;
      gclr = 1'b0;
      @(negedge clk);
      chk("flush", {acc, we, pop, inc, ill}, {m_acc[7:0], 4'h0});
    end
  endtask
  initial
  begin
    #(50 * 3000);
    n_mismatch = n_mismatch + 1;
    final_report;
  end
  initial
  begin
    i = $urandom(60112);
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    for (i = 0; i < 32; i = i + 1)
      run(i % 9);
    $display("test sweep done");
    for (i = 0; i < 400; i = i + 1)
      run($urandom_range(8, 0));
    $display("test random_mix done");
    vld = 1'b0;
    final_report;
  end
endmodule // move_return_rotate_exec_tb
